// >>> logic/rank_pd_ctrl.sv
// per-rank clock enable and power-down sequencer with ahb-lite config port
// assumes the scheduler reports arrivals, queue state and refresh windows in mclk
`timescale 1ns/100ps
module rank_pd_ctrl #(
  parameter int INIT_HOLD = rank_pd_pkg::INIT_HOLD_CYC
) (
  input  wire logic                                mclk,
  input  wire logic                                sys_rst,
  input  wire logic                                clk_en,
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic      [31:0]                         hrdata,
  output logic                                     hreadyout,
  output logic                                     hresp,
  input  wire logic [rank_pd_pkg::NUM_RANKS-1:0]   txn_arrive,
  input  wire logic [rank_pd_pkg::NUM_RANKS-1:0]   txn_queued,
  input  wire logic [rank_pd_pkg::NUM_RANKS-1:0]   banks_closed,
  input  wire logic                                refresh_req,
  input  wire logic                                refresh_done,
  input  wire rank_pd_pkg::pkg_state_t             pkg_state,
  input  wire logic                                ext_graphics,
  input  wire logic                                gfx_idle,
  input  wire logic                                display_pending,
  input  wire logic                                mem_req_pending,
  input  wire logic                                flush_done,
  output rank_pd_pkg::rank_pins_t                  pins,
  output rank_pd_pkg::ctl_out_t                    ctl,
  output logic                                     refresh_ready
);
  import rank_pd_pkg::*;

  // ==========================================================
  // bus slave
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [15:0] pdcfg_q;
  logic        init_done_q;
  logic        tri_en_q;
  logic [3:0]  pop_q;
  logic [3:0]  gfx_q;

  wire         bus_take   = hsel & hready & htrans[1];
  wire         bus_wr     = bus_take & hwrite;
  wire         bus_rd     = bus_take & ~hwrite;
  wire         wr_pdcfg   = wr_pend_q & (wr_addr_q == PDCFG_OFFSET);
  wire         wr_ctrl    = wr_pend_q & (wr_addr_q == CTRL_OFFSET);
  wire  [11:0] rd_addr    = haddr[11:0];

  logic [15:0] status_w;
  wire  [31:0] rd_mux     = (rd_addr == PDCFG_OFFSET)  ? {16'h0000, pdcfg_q} :
                            (rd_addr == CTRL_OFFSET)   ? {20'h00000, gfx_q, pop_q, 2'h0, tri_en_q, init_done_q} :
                            (rd_addr == STATUS_OFFSET) ? {16'h0000, status_w} : 32'h0000_0000;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata    <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_q <= bus_wr;
      if (bus_take) begin
        wr_addr_q <= haddr[11:0];
      end
      if (bus_rd) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // type in 15:12, idle count in 11:0
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pdcfg_q <= PDCFG_RESET;
    end else if (clk_en && wr_pdcfg) begin
      pdcfg_q <= hwdata[15:0];
    end
  end

  // everything populated and driven until software says otherwise
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      init_done_q <= 1'b0;
      tri_en_q    <= 1'b0;
      pop_q       <= POP_RESET;
      gfx_q       <= 4'h0;
    end else if (clk_en && wr_ctrl) begin
      init_done_q <= hwdata[CTRL_INIT_BIT];
      tri_en_q    <= hwdata[CTRL_TRIEN_BIT];
      pop_q       <= hwdata[CTRL_POP_LSB +: NUM_RANKS];
      gfx_q       <= hwdata[CTRL_GFX_LSB +: NUM_RANKS];
    end
  end

  // ==========================================================
  // power-up hold counter
  // software cannot release clock enable before the hold expires
  logic [31:0] hold_q;
  wire         hold_done = (hold_q >= 32'(INIT_HOLD));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= 32'h0000_0000;
    end else if (clk_en && !hold_done) begin
      hold_q <= hold_q + 32'h0000_0001;
    end
  end

  wire         cke_allowed = init_done_q & hold_done;

  // ==========================================================
  // package level decisions
  wire  [3:0]  pd_type   = pdcfg_q[TYPE_MSB:TYPE_LSB];
  wire  [11:0] idle_lim  = pdcfg_q[IDLE_MSB:IDLE_LSB];
  wire         pd_enable = (pd_type == PD_OPEN_PAGE) | (pd_type == PD_PRECHARGED) |
                           (pd_type == PD_DLL_OFF);
  wire         deep_ok   = ext_graphics ? ~mem_req_pending
                                        : (gfx_idle & ~display_pending);
  wire         want_self = (pkg_state == PKG_S3) | ((pkg_state == PKG_DEEP) & deep_ok);
  wire         want_off  = (pkg_state == PKG_S4);

  // flush pending cycles before any rank goes to self-refresh
  logic        flushed_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flushed_q <= 1'b0;
    end else if (clk_en) begin
      if (!want_self) begin
        flushed_q <= 1'b0;
      end else if (flush_done) begin
        flushed_q <= 1'b1;
      end
    end
  end

  wire         self_go   = want_self & flushed_q;
  wire         in_ref_w  = refresh_req & pd_enable;

  // ==========================================================
  // per-rank sequencers
  rank_state_t        st_q   [NUM_RANKS];
  logic [11:0]        idle_q [NUM_RANKS];
  logic [4:0]         exit_q [NUM_RANKS];
  logic [NUM_RANKS-1:0] cke_w;
  logic [NUM_RANKS-1:0] cmd_ok_w;
  logic [NUM_RANKS-1:0] data_ok_w;
  logic [NUM_RANKS-1:0] empty_w;
  logic [NUM_RANKS-1:0] closing_w;
  logic [NUM_RANKS-1:0] awake_w;
  logic [NUM_RANKS-1:0] down_w;
  logic [NUM_RANKS-1:0] empty_q;

  genvar r;
  generate
    for (r = 0; r < NUM_RANKS; r++) begin : g_rank
      wire idle_exp  = (idle_q[r] >= idle_lim);
      wire can_sleep = pd_enable & idle_exp & ~txn_queued[r] & ~txn_arrive[r] & ~in_ref_w;
      wire self_rank = self_go & ~gfx_q[r];
      // full five bits, a one-bit net would truncate both exit delays
      wire [4:0] exit_cnt = (pd_type == PD_DLL_OFF) ? TXPDLL_CYCLES : TXP_CYCLES;
      wire wake      = txn_arrive[r] | txn_queued[r] | in_ref_w | ~pd_enable;
      rank_state_t nxt;

      always_comb begin
        nxt = st_q[r];
        case (st_q[r])
          RK_ACTIVE: begin
            if (want_off) nxt = RK_OFF;
            else if (self_rank) nxt = RK_SELF;
            else if (can_sleep && pd_type != PD_OPEN_PAGE) nxt = RK_CLOSING;
            else if (can_sleep) nxt = RK_DOWN;
          end
          RK_CLOSING: begin
            if (wake) nxt = RK_ACTIVE;
            else if (banks_closed[r]) nxt = RK_DOWN;
          end
          RK_DOWN: begin
            if (want_off) nxt = RK_OFF;
            else if (self_rank) nxt = RK_SELF;
            else if (wake) nxt = RK_EXIT;
          end
          RK_EXIT: begin
            if (exit_q[r] == 5'h00) nxt = RK_ACTIVE;
          end
          RK_SELF: begin
            if (want_off) nxt = RK_OFF;
            else if (!want_self) nxt = RK_EXIT;
          end
          RK_OFF: begin
            if (!want_off) nxt = RK_EXIT;
          end
          default: nxt = RK_ACTIVE;
        endcase
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          st_q[r]   <= RK_ACTIVE;
          idle_q[r] <= 12'h000;
          exit_q[r] <= 5'h00;
          empty_q[r] <= 1'b0;
        end else if (clk_en) begin
          st_q[r] <= cke_allowed ? nxt : RK_ACTIVE;
          if (txn_arrive[r]) idle_q[r] <= 12'h000;
          else if (!idle_exp) idle_q[r] <= idle_q[r] + 12'h001;
          if (st_q[r] != RK_EXIT) exit_q[r] <= 5'(exit_cnt);
          else if (exit_q[r] != 5'h00) exit_q[r] <= exit_q[r] - 5'h01;
          if (nxt == RK_DOWN && st_q[r] == RK_CLOSING) empty_q[r] <= 1'b1;
          else if (txn_arrive[r]) empty_q[r] <= 1'b0;
        end
      end

      // clock enable low in power-down, self-refresh, off and before init
      assign cke_w[r]     = cke_allowed & ((st_q[r] == RK_ACTIVE) | (st_q[r] == RK_CLOSING) |
                                           (st_q[r] == RK_EXIT)) & pop_q[r];
      assign cmd_ok_w[r]  = cke_allowed & ((st_q[r] == RK_ACTIVE) | (st_q[r] == RK_EXIT &&
                            (exit_cnt - exit_q[r]) >= TXP_CYCLES));
      assign data_ok_w[r] = cke_allowed & (st_q[r] == RK_ACTIVE);
      assign empty_w[r]   = empty_q[r];
      assign closing_w[r] = (st_q[r] == RK_CLOSING);
      assign awake_w[r]   = (st_q[r] == RK_ACTIVE);
      assign down_w[r]    = (st_q[r] == RK_DOWN) | (st_q[r] == RK_SELF);
    end
  endgenerate

  // unpopulated ranks float only after software enables it
  wire  [3:0]  unused_w   = ~pop_q & {NUM_RANKS{tri_en_q}};
  wire         io_gate_w  = (pkg_state != PKG_ACTIVE);

  assign status_w = {4'h0, down_w, awake_w, cke_w};

  // ==========================================================
  // registered outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pins          <= '0;
      ctl           <= '0;
      refresh_ready <= 1'b0;
    end else if (clk_en) begin
      pins.cke      <= cke_w & ~unused_w;
      pins.cke_oe_n <= unused_w;
      pins.cs_oe_n  <= unused_w;
      pins.odt_en   <= awake_w & ~unused_w;
      pins.clk_en   <= ~unused_w & ~{NUM_RANKS{want_off}};
      ctl.flush_req <= want_self & ~flushed_q;
      ctl.close_pages <= |closing_w;
      ctl.cmd_ok    <= cmd_ok_w;
      ctl.data_ok   <= data_ok_w;
      ctl.pages_empty <= empty_w;
      ctl.restore_training <= |(awake_w & ~cke_w) ? 1'b0 : (pkg_state == PKG_ACTIVE) & flushed_q;
      ctl.io_keep   <= io_gate_w;
      refresh_ready <= in_ref_w & (&(awake_w | unused_w)) & ~refresh_done;
    end
  end
endmodule : rank_pd_ctrl

// >>> logic/rank_pd_pkg.sv
// constants, types and register map for the rank power-down controller
// assumes one mclk domain and an ahb-lite slave port for configuration
package rank_pd_pkg;
  localparam int          NUM_RANKS       = 4;
  // register byte offsets
  localparam logic [11:0] PDCFG_OFFSET    = 12'h000;
  localparam logic [11:0] CTRL_OFFSET     = 12'h004;
  localparam logic [11:0] STATUS_OFFSET   = 12'h008;
  // field positions
  localparam int          TYPE_MSB        = 15;
  localparam int          TYPE_LSB        = 12;
  localparam int          IDLE_MSB        = 11;
  localparam int          IDLE_LSB        = 0;
  localparam int          CTRL_INIT_BIT   = 0;
  localparam int          CTRL_TRIEN_BIT  = 1;
  localparam int          CTRL_POP_LSB    = 4;
  localparam int          CTRL_GFX_LSB    = 8;
  // reset values
  localparam logic [15:0] PDCFG_RESET     = 16'h0000;
  localparam logic [3:0]  POP_RESET       = 4'hF;
  // power-down type encodings
  localparam logic [3:0]  PD_NONE         = 4'h0;
  localparam logic [3:0]  PD_OPEN_PAGE    = 4'h1;
  localparam logic [3:0]  PD_PRECHARGED   = 4'h2;
  localparam logic [3:0]  PD_DLL_OFF      = 4'h6;
  // exit timing in memory clock cycles
  localparam logic [4:0]  TXP_CYCLES      = 5'h03;
  localparam logic [4:0]  TXPDLL_CYCLES   = 5'h14;
  // power-up hold, 200 us at the 40 MHz clock
  localparam int          INIT_HOLD_US    = 200;
  localparam int          CLK_MHZ         = 40;
  localparam int          INIT_HOLD_CYC   = INIT_HOLD_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PKG_ACTIVE = 2'h0,
    PKG_DEEP   = 2'h1,
    PKG_S3     = 2'h2,
    PKG_S4     = 2'h3
  } pkg_state_t;

  typedef enum logic [2:0] {
    RK_ACTIVE  = 3'b000,
    RK_CLOSING = 3'b001,
    RK_DOWN    = 3'b011,
    RK_EXIT    = 3'b010,
    RK_SELF    = 3'b110,
    RK_OFF     = 3'b111
  } rank_state_t;

  typedef struct packed {
    logic [NUM_RANKS-1:0] cke;
    logic [NUM_RANKS-1:0] cke_oe_n;
    logic [NUM_RANKS-1:0] cs_oe_n;
    logic [NUM_RANKS-1:0] odt_en;
    logic [NUM_RANKS-1:0] clk_en;
  } rank_pins_t;

  typedef struct packed {
    logic                 flush_req;
    logic                 close_pages;
    logic [NUM_RANKS-1:0] cmd_ok;
    logic [NUM_RANKS-1:0] data_ok;
    logic [NUM_RANKS-1:0] pages_empty;
    logic                 restore_training;
    logic                 io_keep;
  } ctl_out_t;
endpackage : rank_pd_pkg

// >>> verif/rank_pd_monitor.sv
// port-level assertion checker for the rank power-down controller
// assumes one mclk domain; bound onto every rank_pd_ctrl instance
`timescale 1ns/100ps
module rank_pd_monitor #(
  parameter int INIT_HOLD = 16
) (
  input wire logic                              mclk,
  input wire logic                              sys_rst,
  input wire logic                              hsel,
  input wire logic [1:0]                        htrans,
  input wire logic                              hwrite,
  input wire logic                              hready,
  input wire logic [rank_pd_pkg::NUM_RANKS-1:0] txn_arrive,
  input wire logic [rank_pd_pkg::NUM_RANKS-1:0] txn_queued,
  input wire rank_pd_pkg::pkg_state_t           pkg_state,
  input wire rank_pd_pkg::rank_pins_t           pins,
  input wire rank_pd_pkg::ctl_out_t             ctl,
  input wire logic                              refresh_ready
);
  import rank_pd_pkg::*;
  // ==========
  // helper state
  logic [15:0] since_q;
  logic        wr_seen_q;
  logic        armed_q;
  // one cycle of margin for the registered outputs
  wire         in_hold = since_q < 16'(INIT_HOLD - 1);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      since_q   <= 16'h0000;
      wr_seen_q <= 1'b0;
      armed_q   <= 1'b0;
    end else begin
      since_q   <= (since_q == 16'hFFFF) ? since_q : since_q + 16'h0001;
      wr_seen_q <= wr_seen_q | (hsel & hready & htrans[1] & hwrite);
      armed_q   <= armed_q | pins.cke[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========
  // sequences and properties
  sequence q_held;
    pins.cke[0] && txn_queued[0] && pkg_state == PKG_ACTIVE ##1 txn_queued[0] [*2];
  endsequence
  sequence woke;
    armed_q && $rose(pins.cke[0]);
  endsequence
  sequence arrive;
    txn_arrive[0] && armed_q && pkg_state == PKG_ACTIVE && !pins.cke_oe_n[0];
  endsequence
  AST_INIT_LOW: assert property (in_hold |-> pins.cke == 4'h0)
    else $error("cke rose inside the power-up hold");
  AST_DRIVEN: assert property (!wr_seen_q |-> pins.cke_oe_n == 4'h0)
    else $error("cke undriven before any write");
  AST_PAIR: assert property (pins.cke_oe_n == pins.cs_oe_n)
    else $error("cke and cs float apart");
  AST_UNUSED: assert property ((pins.cke_oe_n & (pins.odt_en | pins.clk_en)) == 4'h0)
    else $error("unused rank keeps odt or clock");
  AST_QUEUE: assert property (q_held |-> pins.cke[0])
    else $error("rank down with work queued");
  AST_WAKE: assert property (arrive |-> ##[1:8] pins.cke[0])
    else $error("arrival did not wake rank");
  AST_EXIT: assert property (woke |-> !ctl.cmd_ok[0] ##1 !ctl.cmd_ok[0] ##1 !ctl.cmd_ok[0])
    else $error("command allowed inside exit delay");
  AST_DATA: assert property (ctl.data_ok[0] |-> ctl.cmd_ok[0])
    else $error("data allowed before commands");
  AST_REFRESH: assert property (refresh_ready |-> pins.cke[0])
    else $error("refresh ready with rank asleep");
endmodule : rank_pd_monitor

bind rank_pd_ctrl rank_pd_monitor #(.INIT_HOLD(INIT_HOLD)) u_mon (
  .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .txn_arrive(txn_arrive), .txn_queued(txn_queued),
  .pkg_state(pkg_state), .pins(pins), .ctl(ctl), .refresh_ready(refresh_ready));

// >>> verif/ddr_rank_model.sv
// behavioural model of the sdram ranks behind the controller
// assumes pins and ctl come straight from rank_pd_ctrl, mclk domain
`timescale 1ns/100ps
module ddr_rank_model #(
  parameter int CLOSE_LAT = 1
) (
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  input  wire rank_pd_pkg::rank_pins_t           pins,
  input  wire rank_pd_pkg::ctl_out_t             ctl,
  output logic [rank_pd_pkg::NUM_RANKS-1:0]      banks_closed
);
  import rank_pd_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] cke_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q        <= 4'h0;
      cke_q        <= 4'h0;
      banks_closed <= 4'h0;
    end else begin
      cke_q <= pins.cke;
      cnt_q <= ctl.close_pages ? cnt_q + 4'h1 : 4'h0;
      // precharge-all lands only after CLOSE_LAT cycles
      if (ctl.close_pages && cnt_q >= 4'(CLOSE_LAT))
        banks_closed <= 4'hF;
      // a woken rank may open pages again
      else
        banks_closed <= banks_closed & ~(pins.cke & ~cke_q);
    end
  end
endmodule : ddr_rank_model

// >>> verif/dram_rank_power_down_control_tb.sv
// self-checking bench: ahb-lite register access plus rank stimulus
// assumes rank_pd_ctrl, its package and the rank model are compiled first
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WAIT(c) for (k = 0; k < 300 && !(c); k++) @(posedge mclk);
module dram_rank_power_down_control_tb;
  import rank_pd_pkg::*;
  localparam int HOLD = 16;
  logic        mclk, sys_rst, hsel, hwrite, hreadyout, hresp, refresh_ready;
  logic        refresh_req, refresh_done, ext_graphics, gfx_idle, mem_req_pending, flush_done, display_pending;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  txn_arrive, txn_queued, banks_closed, m;
  pkg_state_t  pkg_state;
  rank_pins_t  pins;
  ctl_out_t    ctl;
  int          n_errors, cmp_count, k, n, i;

  rank_pd_ctrl #(.INIT_HOLD(HOLD)) DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .txn_arrive(txn_arrive), .txn_queued(txn_queued),
    .banks_closed(banks_closed), .refresh_req(refresh_req), .refresh_done(refresh_done),
    .pkg_state(pkg_state), .ext_graphics(ext_graphics), .gfx_idle(gfx_idle),
    .display_pending(display_pending), .mem_req_pending(mem_req_pending), .flush_done(flush_done),
    .pins(pins), .ctl(ctl), .refresh_ready(refresh_ready));
  // slow precharge so the closing phase is really exercised
  ddr_rank_model #(.CLOSE_LAT(5)) u_ranks (.mclk(mclk), .sys_rst(sys_rst), .pins(pins),
    .ctl(ctl), .banks_closed(banks_closed));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========
  // bus tasks
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2; hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rdv);
  endtask : wr
  task rd_chk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, rdv);
    `CHK("read", e, rdv)
    `CHK("hresp", 1'b0, hresp)
  endtask : rd_chk
  task conclude;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // ==========
  // tests
  initial begin
    n_errors = 0; cmp_count = 0; sys_rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; txn_arrive = 4'h0; txn_queued = 4'h0;
    refresh_req = 1'b0; refresh_done = 1'b0; pkg_state = PKG_ACTIVE; ext_graphics = 1'b1;
    gfx_idle = 1'b0; mem_req_pending = 1'b0; flush_done = 1'b0; display_pending = 1'b0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    `CHK("cke_oe_n", 4'h0, pins.cke_oe_n)
    rd_chk(32'h000, 32'h00000000);
    rd_chk(32'h004, 32'h000000F0);
    wr(32'h000, 32'h00006080);
    rd_chk(32'h000, 32'h00006080);
    `CHK("cke", 4'h0, pins.cke)
    wr(32'h004, 32'h000000F1);
    `WAIT(pins.cke == 4'hF)
    `CHK("cke", 4'hF, pins.cke)
    for (i = 0; i < 3; i++) begin
      m = (i == 0) ? PD_OPEN_PAGE : (i == 1) ? PD_PRECHARGED : PD_DLL_OFF;
      // rank stays busy until the new mode is in, so it sleeps in that mode
      wr(32'h000, {16'h0000, m, 12'h008});
      txn_queued <= 4'h0;
      `WAIT(!pins.cke[0])
      `CHK("down", 1'b0, pins.cke[0])
      `CHK("closed", m != PD_OPEN_PAGE, banks_closed[0])
      `CHK("empty", m != PD_OPEN_PAGE, ctl.pages_empty[0])
      refresh_req <= 1'b1;
      `WAIT(refresh_ready)
      `CHK("refresh wake", 4'hF, pins.cke)
      refresh_done <= 1'b1;
      refresh_req <= 1'b0;
      @(posedge mclk);
      refresh_done <= 1'b0;
      `WAIT(!pins.cke[0])
      `CHK("refresh sleep", 1'b0, pins.cke[0])
      txn_arrive <= 4'h1;
      txn_queued <= 4'h1;
      @(posedge mclk);
      txn_arrive <= 4'h0;
      for (n = 1; n < 300 && ctl.data_ok[0] !== 1'b1; n++) @(posedge mclk);
      `CHK("lat", 1'b1, (m == PD_DLL_OFF) ? n >= TXPDLL_CYCLES && n < 300
                         : n >= TXP_CYCLES && n < TXPDLL_CYCLES)
    end
    txn_queued <= 4'h0;
    wr(32'h000, {16'h0000, PD_NONE, 12'h008});
    repeat (40) @(posedge mclk);
    `CHK("none", 1'b1, pins.cke[0])
    wr(32'h004, 32'h000002F1);
    ext_graphics <= 1'b0;
    gfx_idle <= 1'b1;
    display_pending <= 1'b1;
    pkg_state <= PKG_DEEP;
    repeat (40) @(posedge mclk);
    `CHK("display busy", 1'b0, ctl.flush_req)
    `CHK("io keep", 1'b1, ctl.io_keep)
    gfx_idle <= 1'b0;
    display_pending <= 1'b0;
    repeat (10) @(posedge mclk);
    `CHK("gfx busy", 1'b0, ctl.flush_req)
    ext_graphics <= 1'b1;
    mem_req_pending <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK("mem busy", 1'b0, ctl.flush_req)
    mem_req_pending <= 1'b0;
    `WAIT(ctl.flush_req)
    `CHK("flush", 1'b1, ctl.flush_req)
    `CHK("no self yet", 1'b1, pins.cke[0])
    flush_done <= 1'b1;
    `WAIT(!pins.cke[0])
    `CHK("self", 1'b0, pins.cke[0])
    pkg_state <= PKG_ACTIVE;
    flush_done <= 1'b0;
    `WAIT(pins.cke[0])
    `CHK("resume", 1'b1, pins.cke[0])
    wr(32'h004, 32'h00000033);
    repeat (3) @(posedge mclk);
    `CHK("float", 4'hC, pins.cke_oe_n)
    `CHK("cs float", 4'hC, pins.cs_oe_n)
    `CHK("odt", 4'h3, pins.odt_en)
    `CHK("clock", 4'h3, pins.clk_en)
    rd_chk(32'h00C, 32'h00000000);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    conclude();
  end
endmodule : dram_rank_power_down_control_tb
